// ---- design/sip_top.sv ----
// two-channel clock-synchronous serial unit: interrupt control, shared port pins, AXI4-Lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
`include "sip_cfg.svh"

// Functional notes
// [RQ1] each channel has separate transmit and receive interrupts, each with own control register
// [RQ2] three-bit priority field selects levels 1 to 7; level zero disables the source
// [RQ3] request is raised only above processor priority level and with global disable clear
// [RQ4] transmit request bit sets when buffer moves into transmit shift register
// [RQ5] receive request bit sets when a completed character moves into receive buffer
// [RQ6] an overrun leaves the receive request bit unchanged
// [RQ7] accepting an interrupt clears its request bit in hardware
// [RQ8] software writes may set or clear each request bit directly
// [RQ9] software clears direction bits of data input pins before receiving; here receive enable forces the data input pin to input in an enabled channel
// [RQ10] flow, clock and data output pins take serial function regardless of direction
// [RQ11] each synchronous transfer is eight bits, least significant bit first
// [RQ12] internal transfer clock is baud divider output divided by two
// [RQ13] data output pin always drives data, filler when only receiving; here no transfer starts without the transmit enable bit
// [RQ14] clock pin drives out with select zero, takes external clock with select one
// [RQ15] flow pin is clear-to-send input with select zero, request-to-send output with one
// [RQ16] data output stays high after mode selection until first transmission
// [RQ17] data input pin stays an ordinary port pin when only transmitting
// [RQ18] peer drives clear-to-send low to let a transmission begin
// [RQ19] request-to-send high when disabled, low when enabled, high receiving, low when done
module sip_top
    import sip_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register bus
    input  wire sip_axi_req_t axi_req,
    output sip_axi_rsp_t      axi_rsp,
    // shared port pins, nibble per channel
    input  wire logic [7:0]   port_in,
    output logic [7:0]        port_out,
    output logic [7:0]        port_oe,
    // processor interrupt interface
    input  wire logic [2:0]   processor_priority_level,
    input  wire logic         int_disable,
    input  wire logic         int_ack,
    input  wire logic [1:0]   int_ack_src,
    output logic              int_request,
    output logic [1:0]        int_source,
    output logic [2:0]        int_level,
    // event interrupt
    output logic              irq
);

    sip_state_t s;
    sip_state_t next_s;

    function automatic logic [7:0] ch_base(input logic idx);
        return idx ? `SIP_CH1_BASE : `SIP_CH0_BASE;
    endfunction

    function automatic logic [7:0] ic_addr(input logic idx, input logic rx);
        return `SIP_R_IC_BASE + (idx ? `SIP_IC_STRIDE : 8'h00) + (rx ? `SIP_IC_RX_OFF : 8'h00);
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        logic hit;
        hit = (a == `SIP_R_DIR) || (a == `SIP_R_PORT_OUT) || (a == `SIP_R_PORT_IN)
            || (a == `SIP_R_EV_STAT) || (a == `SIP_R_EV_CLR) || (a == `SIP_R_EV_EN);
        for (int i = 0; i < 2; i++)
        begin
            hit = hit || (a == ch_base(1'(i)) + `SIP_R_MODE) || (a == ch_base(1'(i)) + `SIP_R_DIV)
                || (a == ch_base(1'(i)) + `SIP_R_TXBUF) || (a == ch_base(1'(i)) + `SIP_R_RXBUF)
                || (a == ch_base(1'(i)) + `SIP_R_STAT)
                || (a == ic_addr(1'(i), 1'b0)) || (a == ic_addr(1'(i), 1'b1));
        end
        return hit;
    endfunction

    // bus handshakes are combinational from state
    always_comb
    begin
        axi_rsp.awready = !s.aw_got && !s.bvalid;
        axi_rsp.wready  = !s.w_got && !s.bvalid;
        axi_rsp.bvalid  = s.bvalid;
        axi_rsp.bresp   = s.bresp;
        axi_rsp.arready = !s.rvalid;
        axi_rsp.rvalid  = s.rvalid;
        axi_rsp.rdata   = s.rdata;
        axi_rsp.rresp   = s.rresp;
    end

    // pin muxing: serial function overrides the direction bits
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                port_out[4*i+k] = s.port_dat[4*i+k];
                port_oe[4*i+k]  = s.dir[4*i+k];
            end
            if (s.ch[i].mode[`SIP_M_ENABLE])
            begin
                port_out[4*i+`SIP_P_TXD] = s.ch[i].out_bit; // [RQ13] [RQ16]
                port_oe[4*i+`SIP_P_TXD]  = 1'b1; // [RQ10]
                port_out[4*i+`SIP_P_CLK] = s.ch[i].sclk;
                port_oe[4*i+`SIP_P_CLK]  = !s.ch[i].mode[`SIP_M_CLK_EXT]; // [RQ14] [RQ10]
                port_out[4*i+`SIP_P_FLOW] = s.ch[i].rts; // [RQ19]
                port_oe[4*i+`SIP_P_FLOW]  = s.ch[i].mode[`SIP_M_RTS_SEL]; // [RQ15] [RQ10]
                // receive pin stays a port pin when only transmitting
                if (s.ch[i].mode[`SIP_M_RX_EN])
                    port_oe[4*i+`SIP_P_RXD] = 1'b0; // [RQ17]
            end
        end
        int_request = s.cpu_req;
        int_source  = s.cpu_src;
        int_level   = s.cpu_lvl;
        irq         = |(s.ev_stat & s.ev_en);
    end

    always_comb
    begin
        logic [1:0] tx_set;
        logic [1:0] rx_set;
        logic [5:0] ev;
        logic       fall;
        logic       rise;
        logic       cts_ok;
        logic       clk_ok;
        logic [7:0] rx_new;
        logic [7:0] a;
        logic [7:0] d;
        logic [2:0] best_lvl;
        logic [1:0] best_src;
        logic [3:0] ctl;
        tx_set   = 2'b00;
        rx_set   = 2'b00;
        ev       = 6'h00;
        fall     = 1'b0;
        rise     = 1'b0;
        cts_ok   = 1'b0;
        clk_ok   = 1'b0;
        rx_new   = 8'h00;
        a        = 8'h00;
        d        = 8'h00;
        best_lvl = 3'h0;
        best_src = 2'h0;
        ctl      = 4'h0;
        next_s   = s;

        // two-flop synchroniser for every pin input
        next_s.pin_s1 = port_in;
        next_s.pin_s2 = s.pin_s1;

        // processor acceptance clears the request bit
        if (int_ack)
        begin
            if (int_ack_src[0])
                next_s.ch[int_ack_src[1]].rx_ctl[`SIP_IC_REQ] = 1'b0; // [RQ7]
            else
                next_s.ch[int_ack_src[1]].tx_ctl[`SIP_IC_REQ] = 1'b0; // [RQ7]
        end

        // read channel
        if (s.rvalid && axi_req.rready)
            next_s.rvalid = 1'b0;
        if (axi_req.arvalid && !s.rvalid)
        begin
            a = axi_req.araddr;
            next_s.rvalid = 1'b1;
            next_s.rresp  = addr_hit(a) ? `SIP_RESP_OKAY : `SIP_RESP_SLVERR;
            next_s.rdata  = 32'h0000_0000;
            unique case (a)
                `SIP_R_DIR:      next_s.rdata[7:0] = s.dir;
                `SIP_R_PORT_OUT: next_s.rdata[7:0] = s.port_dat;
                `SIP_R_PORT_IN:  next_s.rdata[7:0] = s.pin_s2;
                `SIP_R_EV_STAT:  next_s.rdata[5:0] = s.ev_stat;
                `SIP_R_EV_EN:    next_s.rdata[5:0] = s.ev_en;
                default:         next_s.rdata = 32'h0000_0000;
            endcase
            for (int i = 0; i < 2; i++)
            begin
                if (a == ch_base(1'(i)) + `SIP_R_MODE)
                    next_s.rdata[4:0] = s.ch[i].mode;
                if (a == ch_base(1'(i)) + `SIP_R_DIV)
                    next_s.rdata[7:0] = s.ch[i].div;
                if (a == ch_base(1'(i)) + `SIP_R_RXBUF)
                begin
                    next_s.rdata[7:0]    = s.ch[i].rxbuf;
                    next_s.ch[i].rx_full = 1'b0;
                end
                if (a == ch_base(1'(i)) + `SIP_R_STAT)
                    next_s.rdata[4:0] = {s.ch[i].xfer == SIP_SHIFT && s.ch[i].rx_on, s.ch[i].overrun,
                                         s.ch[i].rx_full, s.ch[i].xfer == SIP_IDLE, !s.ch[i].txbuf_full};
                if (a == ic_addr(1'(i), 1'b0))
                    next_s.rdata[3:0] = s.ch[i].tx_ctl;
                if (a == ic_addr(1'(i), 1'b1))
                    next_s.rdata[3:0] = s.ch[i].rx_ctl;
            end
        end

        // transfer engines
        for (int i = 0; i < 2; i++)
        begin
            fall   = 1'b0;
            rise   = 1'b0;
            cts_ok = s.ch[i].mode[`SIP_M_RTS_SEL] || !s.pin_s2[4*i+`SIP_P_FLOW]; // [RQ18]
            clk_ok = !s.ch[i].mode[`SIP_M_CLK_EXT] || s.pin_s2[4*i+`SIP_P_CLK];
            next_s.ch[i].clk_d = s.pin_s2[4*i+`SIP_P_CLK];
            rx_new = {s.pin_s2[4*i+`SIP_P_RXD], s.ch[i].rx_shift[7:1]}; // [RQ11]
            if (!s.ch[i].mode[`SIP_M_ENABLE])
            begin
                next_s.ch[i].xfer    = SIP_IDLE;
                next_s.ch[i].sclk    = 1'b1;
                next_s.ch[i].out_bit = 1'b1; // [RQ16]
            end
            else
            begin
                unique case (s.ch[i].xfer)
                    SIP_IDLE:
                    begin
                        next_s.ch[i].sclk = 1'b1;
                        next_s.ch[i].brg  = s.ch[i].div;
                        if (s.ch[i].mode[`SIP_M_TX_EN] && s.ch[i].txbuf_full && cts_ok && clk_ok)
                        begin
                            next_s.ch[i].tx_shift   = s.ch[i].txbuf;
                            next_s.ch[i].txbuf_full = 1'b0;
                            next_s.ch[i].bitcnt     = 4'h0;
                            next_s.ch[i].rx_on      = s.ch[i].mode[`SIP_M_RX_EN];
                            next_s.ch[i].xfer       = SIP_SHIFT;
                            tx_set[i] = 1'b1; // [RQ4]
                        end
                    end
                    SIP_SHIFT:
                    begin
                        if (s.ch[i].mode[`SIP_M_CLK_EXT])
                        begin
                            fall = s.ch[i].clk_d && !s.pin_s2[4*i+`SIP_P_CLK]; // [RQ14]
                            rise = !s.ch[i].clk_d && s.pin_s2[4*i+`SIP_P_CLK];
                        end
                        else if (s.ch[i].brg == 8'h00)
                        begin
                            // every divider tick toggles, so one clock period is two ticks
                            next_s.ch[i].brg  = s.ch[i].div;
                            next_s.ch[i].sclk = !s.ch[i].sclk; // [RQ12]
                            fall = s.ch[i].sclk;
                            rise = !s.ch[i].sclk;
                        end
                        else
                            next_s.ch[i].brg = s.ch[i].brg - 8'h01;
                        if (fall)
                        begin
                            next_s.ch[i].out_bit  = s.ch[i].tx_shift[0]; // [RQ11] [RQ13]
                            next_s.ch[i].tx_shift = {1'b1, s.ch[i].tx_shift[7:1]};
                        end
                        if (rise)
                        begin
                            next_s.ch[i].rx_shift = rx_new;
                            next_s.ch[i].bitcnt   = s.ch[i].bitcnt + 4'h1;
                            if (s.ch[i].bitcnt + 4'h1 == `SIP_XFER_BITS) // [RQ11]
                            begin
                                next_s.ch[i].xfer = SIP_IDLE;
                                ev[3*i+`SIP_EV_TX] = 1'b1;
                                if (s.ch[i].rx_on)
                                begin
                                    next_s.ch[i].rxbuf   = rx_new;
                                    next_s.ch[i].rx_full = 1'b1;
                                    ev[3*i+`SIP_EV_RX] = 1'b1;
                                    // unread buffer is overwritten; request bit left alone
                                    if (next_s.ch[i].rx_full && s.ch[i].rx_full)
                                    begin
                                        next_s.ch[i].overrun = 1'b1;
                                        ev[3*i+`SIP_EV_OVR] = 1'b1; // [RQ6]
                                    end
                                    else
                                        rx_set[i] = 1'b1; // [RQ5]
                                end
                            end
                        end
                    end
                endcase
            end
            if (!s.ch[i].mode[`SIP_M_RX_EN])
            begin
                next_s.ch[i].rx_on   = 1'b0;
                next_s.ch[i].rx_full = 1'b0;
                next_s.ch[i].overrun = 1'b0;
            end
            next_s.ch[i].rts = !s.ch[i].mode[`SIP_M_RX_EN]
                || (next_s.ch[i].xfer == SIP_SHIFT && next_s.ch[i].rx_on); // [RQ19]
        end

        // write channel: address and data taken in either order
        if (axi_req.awvalid && !s.aw_got && !s.bvalid)
        begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s.w_got && !s.bvalid)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req.wdata;
            next_s.wstrb = axi_req.wstrb;
        end
        if (s.bvalid && axi_req.bready)
            next_s.bvalid = 1'b0;
        if (s.aw_got && s.w_got)
        begin
            a = s.aw_addr;
            d = s.wdata[7:0];
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = addr_hit(a) ? `SIP_RESP_OKAY : `SIP_RESP_SLVERR;
            if (s.wstrb[0])
            begin
                if (a == `SIP_R_DIR)
                    next_s.dir = d;
                if (a == `SIP_R_PORT_OUT)
                    next_s.port_dat = d;
                if (a == `SIP_R_EV_EN)
                    next_s.ev_en = d[5:0];
                if (a == `SIP_R_EV_CLR)
                    next_s.ev_stat = s.ev_stat & ~d[5:0];
                for (int i = 0; i < 2; i++)
                begin
                    if (a == ch_base(1'(i)) + `SIP_R_MODE)
                    begin
                        next_s.ch[i].mode = d[4:0];
                        // enabling a disabled channel parks the data line high
                        if (d[`SIP_M_ENABLE] && !s.ch[i].mode[`SIP_M_ENABLE])
                            next_s.ch[i].out_bit = 1'b1; // [RQ16]
                    end
                    if (a == ch_base(1'(i)) + `SIP_R_DIV)
                        next_s.ch[i].div = d;
                    if (a == ch_base(1'(i)) + `SIP_R_TXBUF)
                    begin
                        next_s.ch[i].txbuf      = d;
                        next_s.ch[i].txbuf_full = 1'b1;
                    end
                    if (a == ic_addr(1'(i), 1'b0))
                        next_s.ch[i].tx_ctl = d[3:0]; // [RQ1] [RQ8]
                    if (a == ic_addr(1'(i), 1'b1))
                        next_s.ch[i].rx_ctl = d[3:0]; // [RQ1] [RQ8]
                end
            end
        end

        // hardware sets land last so they win over any clear in the same cycle
        for (int i = 0; i < 2; i++)
        begin
            if (tx_set[i])
                next_s.ch[i].tx_ctl[`SIP_IC_REQ] = 1'b1; // [RQ4]
            if (rx_set[i])
                next_s.ch[i].rx_ctl[`SIP_IC_REQ] = 1'b1; // [RQ5]
        end
        next_s.ev_stat = next_s.ev_stat | ev;

        // arbitration over the four sources; lower index wins a tie
        for (int j = 0; j < 4; j++)
        begin
            ctl = j[0] ? next_s.ch[j[1]].rx_ctl : next_s.ch[j[1]].tx_ctl;
            if (ctl[`SIP_IC_REQ] && ctl[2:0] > best_lvl) // [RQ2]
            begin
                best_lvl = ctl[2:0];
                best_src = 2'(j);
            end
        end
        next_s.cpu_req = (best_lvl > processor_priority_level) && !int_disable; // [RQ3]
        next_s.cpu_src = best_src;
        next_s.cpu_lvl = best_lvl;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            for (int i = 0; i < 2; i++)
            begin
                s.ch[i].mode    <= `SIP_MODE_RST;
                s.ch[i].div     <= `SIP_DIV_RST;
                s.ch[i].xfer    <= SIP_IDLE;
                s.ch[i].sclk    <= 1'b1;
                s.ch[i].out_bit <= 1'b1;
                s.ch[i].rts     <= 1'b1;
                s.ch[i].tx_ctl  <= `SIP_IC_RST;
                s.ch[i].rx_ctl  <= `SIP_IC_RST;
            end
            s.dir <= `SIP_DIR_RST;
        end
        else
            s <= next_s;
    end

endmodule
`default_nettype wire

// ---- design/sip_cfg.svh ----
// register offsets, field positions, reset values and widths of the serial interrupt and pin block
`ifndef SIP_CFG_SVH
`define SIP_CFG_SVH

`define SIP_AW            8
// per-channel registers, relative to the channel base
`define SIP_CH0_BASE      8'h00
`define SIP_CH1_BASE      8'h20
`define SIP_R_MODE        8'h00
`define SIP_R_DIV         8'h04
`define SIP_R_TXBUF       8'h08
`define SIP_R_RXBUF       8'h0C
`define SIP_R_STAT        8'h10
// shared port
`define SIP_R_DIR         8'h14
`define SIP_R_PORT_OUT    8'h18
`define SIP_R_PORT_IN     8'h1C
// interrupt control registers: tx at base + 8*ch, rx at base + 8*ch + 4
`define SIP_R_IC_BASE     8'h34
`define SIP_IC_RX_OFF     8'h04
`define SIP_IC_STRIDE     8'h08
// event status (read only), clear (write only), enable
`define SIP_R_EV_STAT     8'h44
`define SIP_R_EV_CLR      8'h48
`define SIP_R_EV_EN       8'h4C

// mode register fields
`define SIP_M_ENABLE      0
`define SIP_M_TX_EN       1
`define SIP_M_RTS_SEL     2
`define SIP_M_CLK_EXT     3
`define SIP_M_RX_EN       4
// interrupt control fields
`define SIP_IC_REQ        3
// pin positions within a channel's nibble of the shared port
`define SIP_P_FLOW        0
`define SIP_P_CLK         1
`define SIP_P_RXD         2
`define SIP_P_TXD         3
// event status bits per channel (base 3*ch)
`define SIP_EV_TX         0
`define SIP_EV_RX         1
`define SIP_EV_OVR        2

`define SIP_DIR_RST       8'h00
`define SIP_MODE_RST      5'h00
`define SIP_DIV_RST       8'h00
`define SIP_IC_RST        4'h0
`define SIP_XFER_BITS     4'h8
`define SIP_RESP_OKAY     2'h0
`define SIP_RESP_SLVERR   2'h2

`endif

// ---- design/sip_pkg.sv ----
// types shared by the serial interrupt and pin block
`default_nettype none
package sip_pkg;

    typedef enum logic [1:0]
    {
        SIP_IDLE  = 2'b01,
        SIP_SHIFT = 2'b10
    } sip_xfer_t;

    typedef struct packed
    {
        logic       awvalid;
        logic [7:0] awaddr;
        logic       wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bready;
        logic       arvalid;
        logic [7:0] araddr;
        logic       rready;
    } sip_axi_req_t;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sip_axi_rsp_t;

    typedef struct packed
    {
        logic [4:0] mode;
        logic [7:0] div;
        logic [7:0] brg;
        logic       sclk;
        logic [7:0] txbuf;
        logic       txbuf_full;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [3:0] bitcnt;
        sip_xfer_t  xfer;
        logic       rx_on;
        logic       out_bit;
        logic [7:0] rxbuf;
        logic       rx_full;
        logic       overrun;
        logic       rts;
        logic [3:0] tx_ctl;
        logic [3:0] rx_ctl;
        logic       clk_d;
    } sip_chan_t;

    typedef struct packed
    {
        sip_chan_t [1:0] ch;
        logic [7:0]  dir;
        logic [7:0]  port_dat;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [5:0]  ev_stat;
        logic [5:0]  ev_en;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        cpu_req;
        logic [1:0]  cpu_src;
        logic [2:0]  cpu_lvl;
    } sip_state_t;

endpackage
`default_nettype wire

// ---- tb/sip_props.sv ----
// port assertions for the serial interrupt and pin block
`default_nettype none
module sip_props
    import sip_pkg::*;
(
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // register bus
    input wire sip_axi_req_t axi_req,
    input wire sip_axi_rsp_t axi_rsp,
    // shared port
    input wire logic [7:0]   port_in,
    input wire logic [7:0]   port_out,
    input wire logic [7:0]   port_oe,
    // processor interrupt
    input wire logic [2:0]   processor_priority_level,
    input wire logic         int_disable,
    input wire logic         int_ack,
    input wire logic [1:0]   int_ack_src,
    input wire logic         int_request,
    input wire logic [1:0]   int_source,
    input wire logic [2:0]   int_level,
    input wire logic         irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    chk_req_level: assert property (int_request |-> int_level != 3'h0)
        else $error("request at level zero");
    chk_req_ipl: assert property (int_request |->
        int_level > $past(processor_priority_level) && !$past(int_disable))
        else $error("request not above priority or while disabled");
    // write lands one edge after both are held, answer shows the edge after that
    chk_wr_resp: assert property (s_wr_both |-> ##2 axi_rsp.bvalid)
        else $error("write response late");
    chk_b_done: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response not retired");
    chk_rd_resp: assert property (s_rd_take |=> axi_rsp.rvalid)
        else $error("read response late");
    chk_r_done: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read response not retired");
    chk_ar_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while answer pending");
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> port_oe == 8'h00 && !irq)
        else $error("pins or irq active after reset");
endmodule
bind sip_top sip_props sip_props_inst (.*);
`default_nettype wire

// ---- tb/sip_peer.sv ----
// serial peer on channel 0: clear-to-send source, byte source and sink
`default_nettype none
module sip_peer
(
    // pins seen from the device
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0]     pin_in,
    // test control
    input wire logic       cts_n,
    input wire logic [7:0] tx_byte,
    output logic [7:0]     rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] k = 3'h0;
    logic       d = 1'b1;
    assign pin_in = {pin_out[3], d, pin_out[1], cts_n};
    // count only driven falls, the reset glitch must not skew the bit index
    always @(negedge pin_out[1])
    begin
        if (pin_oe[1] === 1'b1)
        begin
            d <= tx_byte[k];
            k <= k + 3'h1;
        end
    end
    always @(posedge pin_out[1])
        rx_byte <= {pin_out[3], rx_byte[7:1]};
endmodule
`default_nettype wire

// ---- tb/sip_top_tb.sv ----
// testbench for the serial interrupt and pin block
`default_nettype none
module sip_top_tb;
    import sip_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    sip_axi_req_t req = '0;
    sip_axi_rsp_t rsp;
    logic [7:0]   port_out, port_oe, rx_byte;
    logic [3:0]   peer_in;
    logic [2:0]   ppl = 3'h0, int_level;
    logic         int_dis = 1'b0, ack = 1'b0, cts_n = 1'b1, int_request, irq;
    logic [1:0]   ack_src = 2'h0, int_source, r;
    logic [31:0]  q;
    int           fail_count = 0, num_checks = 0, i, n;
    always #2 aclk = ~aclk;
    sip_top sip_top_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .port_in({4'h5, peer_in}), .port_out(port_out), .port_oe(port_oe), .processor_priority_level(ppl),
        .int_disable(int_dis), .int_ack(ack), .int_ack_src(ack_src), .int_request(int_request),
        .int_source(int_source), .int_level(int_level), .irq(irq));
    sip_peer sip_peer_inst (.pin_out(port_out[3:0]), .pin_oe(port_oe[3:0]), .pin_in(peer_in),
        .cts_n(cts_n), .tx_byte(8'hA6), .rx_byte(rx_byte));
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // sample ready and answer mid-cycle, act on the next rising edge
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        sip_axi_rsp_t s;
        int           k;
        @(posedge aclk);
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        {req.awvalid, req.wvalid, req.bready} <= {3{wr}};
        {req.arvalid, req.rready} <= {2{!wr}};
        for (k = 0; k < 50; k++)
        begin
            @(negedge aclk);
            s = rsp;
            @(posedge aclk);
            if (s.awready) req.awvalid <= 1'b0;
            if (s.wready) req.wvalid <= 1'b0;
            if (s.arready) req.arvalid <= 1'b0;
            q = s.rdata;
            r = wr ? s.bresp : s.rresp;
            if (wr ? s.bvalid : s.rvalid) break;
        end
        {req.bready, req.rready} <= 2'b00;
        if (k == 50)
        begin
            fail_count++;
            finish_test;
        end
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, 8'h14, 0); check(q, 32'h00);
        bus(1, 8'h14, 32'hA5); bus(0, 8'h14, 0); check(q, 32'hA5);
        bus(1, 8'h14, 0); bus(0, 8'hFC, 0); check(r, 2'h2);
        ppl <= 3'h2;
        bus(1, 8'h3C, 32'h0B); @(negedge aclk);
        check({int_request, int_source, int_level}, {1'b1, 2'h2, 3'h3});
        @(posedge aclk); ppl <= 3'h3; repeat (2) @(negedge aclk); check(int_request, 0);
        @(posedge aclk); ppl <= 3'h0; int_dis <= 1'b1; repeat (2) @(negedge aclk); check(int_request, 0);
        @(posedge aclk); int_dis <= 1'b0; ack <= 1'b1; ack_src <= 2'h2;
        @(posedge aclk); ack <= 1'b0;
        bus(0, 8'h3C, 0); check(q, 32'h03);
        bus(1, 8'h40, 32'h08); @(negedge aclk); check(int_request, 0);
        bus(1, 8'h40, 0); bus(0, 8'h40, 0); check(q, 32'h00);
        bus(1, 8'h20, 32'h05); @(negedge aclk); check({port_oe[4], port_out[4]}, 2'b11);
        bus(1, 8'h20, 32'h15); @(negedge aclk); check(port_out[4], 0);
        bus(1, 8'h04, 32'h07); bus(1, 8'h00, 32'h13); bus(1, 8'h4C, 32'h04); bus(1, 8'h08, 32'h3C);
        // peer holds clear-to-send high, so no start may happen
        repeat (40) @(posedge aclk);
        @(negedge aclk); check({port_oe[3:0], port_out[3]}, 5'h15);
        bus(0, 8'h34, 0); check(q, 32'h00);
        @(posedge aclk); cts_n <= 1'b0;
        // third byte lands on an unread buffer: overrun
        for (i = 0; i < 3; i++)
        begin
            bus(1, 8'h48, 32'h03);
            if (i > 0) bus(1, 8'h08, 32'h3C + i);
            q = 0;
            for (n = 0; n < 200 && q[0] !== 1'b1; n++) bus(0, 8'h44, 0);
            if (n == 200) begin fail_count++; finish_test; end
            check(rx_byte, 32'h3C + i);
            bus(0, 8'h34, 0); check(q, 32'h08);
            bus(0, 8'h38, 0); check(q, i < 2 ? 32'h08 : 32'h00);
            bus(1, 8'h34, 0); bus(1, 8'h38, 0);
            if (i == 0) begin bus(0, 8'h0C, 0); check(q, 32'hA6); end
            @(negedge aclk); check(irq, i == 2);
        end
        bus(1, 8'h48, 32'h3F); @(negedge aclk); check(irq, 0);
        finish_test;
    end
endmodule
`default_nettype wire
